// File: logic/ubr_boot_ctrl.sv
// ubr_boot_ctrl: power-up eeprom boot selection and usb re-enumeration control.
// assumes firmware bits and setup strobes come from logic on i_clk; sda is a pin.
//
// Functional notes
// - at power-up read eeprom first byte; only 0xC0 and 0xC2 count.
// - code 0xC0: vendor, product and release ids come from eeprom.
// - code 0xC2: eeprom contents are copied into internal ram.
// - no eeprom: enumerate with built-in descriptors and default ids.
// - i2c port is master only, at 100 or 400 kHz.
// - usb signals only at full speed, 12 Mbps.
// - neither low speed nor high speed is supported.
// - enumerate on attach, take download, then enumerate again as new device.
// - soft_disconnect 1 detaches from usb; 0 reconnects.
// - request_handling_select 0: built-in logic answers endpoint-zero requests.
// - request_handling_select 1: endpoint-zero requests go to firmware.
`timescale 1ns/1ns

module ubr_boot_ctrl #(
  parameter logic [15:0] VID_DEFAULT = ubr_pkg::DEF_VID,
  parameter logic [15:0] PID_DEFAULT = ubr_pkg::DEF_PID,
  parameter logic [15:0] DID_DEFAULT = ubr_pkg::DEF_DID,
  parameter int unsigned RAM_AW      = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_i2c_fast,
  input  wire logic              i_sda,
  output logic                   o_scl_out,
  output logic                   o_scl_oe,
  output logic                   o_sda_out,
  output logic                   o_sda_oe,
  input  wire logic              i_soft_disconnect,
  input  wire logic              i_request_handling_select,
  input  wire logic              i_setup_valid,
  output logic                   o_boot_done,
  output logic                   o_cpu_hold,
  output logic [1:0]             o_boot_mode,
  output logic [15:0]            o_vid,
  output logic [15:0]            o_pid,
  output logic [15:0]            o_did,
  output logic                   o_builtin_desc,
  output logic                   o_ram_we,
  output logic [RAM_AW-1:0]      o_ram_addr,
  output logic [7:0]             o_ram_wdata,
  output logic                   o_dp_pullup,
  output logic                   o_full_speed,
  output logic [1:0]             o_enum_count,
  output logic                   o_setup_to_default,
  output logic                   o_setup_to_fw
);

  // ----------------------------------------------------------------
  // boot sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [11:0] {
    BS_START  = 12'h001,
    BS_DEVW   = 12'h002,
    BS_OFS    = 12'h004,
    BS_RSTART = 12'h008,
    BS_DEVR   = 12'h010,
    BS_CODE   = 12'h020,
    BS_ID     = 12'h040,
    BS_HDR    = 12'h080,
    BS_DATA   = 12'h100,
    BS_FLUSH  = 12'h200,
    BS_STOP   = 12'h400,
    BS_RUN    = 12'h800
  } ubr_boot_st_t;

  ubr_boot_st_t           st_ff, nxt_st;
  ubr_pkg::ubr_boot_mode_t mode_ff, nxt_mode;
  ubr_pkg::ubr_i2c_cmd_t  cmd_ff, nxt_cmd, cur_cmd;
  logic                   go_ff, nxt_go;
  logic                   wait_ff, nxt_wait;
  logic [7:0]             wdata_ff, nxt_wdata, cur_wdata;
  logic                   nack_ff, nxt_nack, cur_nack;
  logic [15:0]            cnt_ff, nxt_cnt;
  logic [15:0]            len_ff, nxt_len;
  logic [47:0]            ids_ff, nxt_ids;
  logic [31:0]            hdr_ff, nxt_hdr;
  logic [RAM_AW-1:0]      ptr_ff, nxt_ptr;
  logic                   done_boot_ff, nxt_done_boot;
  logic [15:0]            vid_ff, nxt_vid;
  logic [15:0]            pid_ff, nxt_pid;
  logic [15:0]            did_ff, nxt_did;
  logic                   ram_we_ff, nxt_ram_we;
  logic [RAM_AW-1:0]      ram_addr_ff, nxt_ram_addr;
  logic [7:0]             ram_wdata_ff, nxt_ram_wdata;

  logic                   tick;
  logic                   i2c_done;
  logic [7:0]             i2c_rdata;
  logic                   i2c_ack;
  logic                   scl_oe;
  logic                   sda_oe;

  // ----------------------------------------------------------------
  // i2c engine
  // ----------------------------------------------------------------
  // 100 or 400 kHz rate
  ubr_tick u_tick (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_fast (i_i2c_fast),
    .o_tick (tick)
  );

  ubr_i2c_master u_i2c (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_tick   (tick),
    .i_go     (go_ff),
    .i_cmd    (cmd_ff),
    .i_wdata  (wdata_ff),
    .i_nack   (nack_ff),
    .i_sda    (i_sda),
    .o_done   (i2c_done),
    .o_rdata  (i2c_rdata),
    .o_ack    (i2c_ack),
    .o_scl_oe (scl_oe),
    .o_sda_oe (sda_oe)
  );

  // ----------------------------------------------------------------
  // per-state bus operation
  // ----------------------------------------------------------------
  always_comb begin
    cur_cmd   = ubr_pkg::I2C_READ;
    cur_wdata = 8'hFF;
    cur_nack  = 1'b0;
    unique case (st_ff)
      BS_START, BS_RSTART: cur_cmd = ubr_pkg::I2C_START;
      BS_DEVW: begin
        cur_cmd   = ubr_pkg::I2C_WRITE;
        cur_wdata = ubr_pkg::EE_WR;
      end
      BS_OFS: begin
        cur_cmd   = ubr_pkg::I2C_WRITE;
        cur_wdata = ubr_pkg::EE_START_OFS;
      end
      BS_DEVR: begin
        cur_cmd   = ubr_pkg::I2C_WRITE;
        cur_wdata = ubr_pkg::EE_RD;
      end
      BS_CODE, BS_HDR: cur_nack = 1'b0;
      BS_ID:    cur_nack = (cnt_ff == ubr_pkg::ID_BYTES - 16'h1);
      BS_DATA:  cur_nack = (cnt_ff == len_ff - 16'h1);
      BS_FLUSH: cur_nack = 1'b1;
      BS_STOP:  cur_cmd  = ubr_pkg::I2C_STOP;
      BS_RUN:   cur_nack = 1'b1;
      default:  cur_nack = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // boot sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_mode      = mode_ff;
    nxt_cmd       = cmd_ff;
    nxt_wdata     = wdata_ff;
    nxt_nack      = nack_ff;
    nxt_go        = 1'b0;
    nxt_wait      = wait_ff;
    nxt_cnt       = cnt_ff;
    nxt_len       = len_ff;
    nxt_ids       = ids_ff;
    nxt_hdr       = hdr_ff;
    nxt_ptr       = ptr_ff;
    nxt_done_boot = done_boot_ff;
    nxt_vid       = vid_ff;
    nxt_pid       = pid_ff;
    nxt_did       = did_ff;
    nxt_ram_we    = 1'b0;
    nxt_ram_addr  = ram_addr_ff;
    nxt_ram_wdata = ram_wdata_ff;
    if ((st_ff != BS_RUN) && !wait_ff) begin
      nxt_go    = 1'b1;
      nxt_wait  = 1'b1;
      nxt_cmd   = cur_cmd;
      nxt_wdata = cur_wdata;
      nxt_nack  = cur_nack;
    end else if ((st_ff != BS_RUN) && i2c_done) begin
      nxt_wait = 1'b0;
      nxt_cnt  = cnt_ff + 16'h1;
      unique case (st_ff)
        BS_START:  nxt_st = BS_DEVW;
        BS_DEVW:   nxt_st = i2c_ack ? BS_OFS : BS_STOP;
        BS_OFS:    nxt_st = i2c_ack ? BS_RSTART : BS_STOP;
        BS_RSTART: nxt_st = BS_DEVR;
        BS_DEVR:   nxt_st = i2c_ack ? BS_CODE : BS_STOP;
        BS_CODE: begin
          nxt_cnt = 16'h0;
          if (i2c_rdata == ubr_pkg::CODE_ID) begin
            nxt_mode = ubr_pkg::BOOT_ID;
            nxt_st   = BS_ID;
          end else if (i2c_rdata == ubr_pkg::CODE_LOAD) begin
            nxt_mode = ubr_pkg::BOOT_LOAD;
            nxt_st   = BS_HDR;
          end else begin
            nxt_mode = ubr_pkg::BOOT_NONE;
            nxt_st   = BS_FLUSH;
          end
        end
        BS_ID: begin
          nxt_ids = {i2c_rdata, ids_ff[47:8]};
          if (cnt_ff == ubr_pkg::ID_BYTES - 16'h1) begin
            nxt_st = BS_STOP;
          end
        end
        BS_HDR: begin
          nxt_hdr = {hdr_ff[23:0], i2c_rdata};
          if (cnt_ff == ubr_pkg::HDR_BYTES - 16'h1) begin
            nxt_cnt = 16'h0;
            nxt_len = nxt_hdr[31:16];
            nxt_ptr = nxt_hdr[RAM_AW-1:0];
            nxt_st  = (nxt_hdr[31:16] == 16'h0) ? BS_FLUSH : BS_DATA;
          end
        end
        BS_DATA: begin
          nxt_ram_we    = 1'b1;
          nxt_ram_addr  = ptr_ff;
          nxt_ram_wdata = i2c_rdata;
          nxt_ptr       = ptr_ff + RAM_AW'(1);
          if (cnt_ff == len_ff - 16'h1) begin
            nxt_st = BS_STOP;
          end
        end
        BS_FLUSH: nxt_st = BS_STOP;
        BS_STOP: begin
          nxt_st        = BS_RUN;
          nxt_done_boot = 1'b1;
          if (mode_ff == ubr_pkg::BOOT_ID) begin
            nxt_vid = {ids_ff[15:8], ids_ff[7:0]};
            nxt_pid = {ids_ff[31:24], ids_ff[23:16]};
            nxt_did = {ids_ff[47:40], ids_ff[39:32]};
          end
        end
        default: nxt_st = BS_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff        <= BS_START;
      mode_ff      <= ubr_pkg::BOOT_NONE;
      cmd_ff       <= ubr_pkg::I2C_START;
      wdata_ff     <= 8'hFF;
      nack_ff      <= 1'b0;
      go_ff        <= 1'b0;
      wait_ff      <= 1'b0;
      cnt_ff       <= 16'h0;
      len_ff       <= 16'h0;
      ids_ff       <= 48'h0;
      hdr_ff       <= 32'h0;
      ptr_ff       <= '0;
      done_boot_ff <= 1'b0;
      vid_ff       <= VID_DEFAULT;
      pid_ff       <= PID_DEFAULT;
      did_ff       <= DID_DEFAULT;
      ram_we_ff    <= 1'b0;
      ram_addr_ff  <= '0;
      ram_wdata_ff <= 8'h00;
    end else begin
      st_ff        <= nxt_st;
      mode_ff      <= nxt_mode;
      cmd_ff       <= nxt_cmd;
      wdata_ff     <= nxt_wdata;
      nack_ff      <= nxt_nack;
      go_ff        <= nxt_go;
      wait_ff      <= nxt_wait;
      cnt_ff       <= nxt_cnt;
      len_ff       <= nxt_len;
      ids_ff       <= nxt_ids;
      hdr_ff       <= nxt_hdr;
      ptr_ff       <= nxt_ptr;
      done_boot_ff <= nxt_done_boot;
      vid_ff       <= nxt_vid;
      pid_ff       <= nxt_pid;
      did_ff       <= nxt_did;
      ram_we_ff    <= nxt_ram_we;
      ram_addr_ff  <= nxt_ram_addr;
      ram_wdata_ff <= nxt_ram_wdata;
    end
  end

  // ----------------------------------------------------------------
  // usb attach and endpoint-zero routing
  // ----------------------------------------------------------------
  logic       pullup_ff, nxt_pullup;
  logic [1:0] enum_ff, nxt_enum;
  logic       set_def_ff, nxt_set_def;
  logic       set_fw_ff, nxt_set_fw;
  logic       builtin_ff, nxt_builtin;

  always_comb begin
    nxt_pullup  = done_boot_ff & ~i_soft_disconnect;
    nxt_enum    = enum_ff;
    if (nxt_pullup && !pullup_ff && (enum_ff != ubr_pkg::ENUM_MAX)) begin
      nxt_enum = enum_ff + 2'h1;
    end
    nxt_set_def = i_setup_valid & pullup_ff & ~i_request_handling_select;
    nxt_set_fw  = i_setup_valid & pullup_ff & i_request_handling_select;
    nxt_builtin = done_boot_ff & (mode_ff != ubr_pkg::BOOT_LOAD);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pullup_ff  <= 1'b0;
      enum_ff    <= 2'h0;
      set_def_ff <= 1'b0;
      set_fw_ff  <= 1'b0;
      builtin_ff <= 1'b0;
    end else begin
      pullup_ff  <= nxt_pullup;
      enum_ff    <= nxt_enum;
      set_def_ff <= nxt_set_def;
      set_fw_ff  <= nxt_set_fw;
      builtin_ff <= nxt_builtin;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain lines: the driven level is always low
  assign o_scl_out          = 1'b0;
  assign o_sda_out          = 1'b0;
  assign o_scl_oe           = scl_oe;
  assign o_sda_oe           = sda_oe;
  assign o_boot_done        = done_boot_ff;
  assign o_cpu_hold         = ~done_boot_ff;
  assign o_boot_mode        = mode_ff;
  assign o_vid              = vid_ff;
  assign o_pid              = pid_ff;
  assign o_did              = did_ff;
  assign o_builtin_desc     = builtin_ff;
  assign o_ram_we           = ram_we_ff;
  assign o_ram_addr         = ram_addr_ff;
  assign o_ram_wdata        = ram_wdata_ff;
  assign o_dp_pullup        = pullup_ff;
  assign o_full_speed       = 1'b1;
  assign o_enum_count       = enum_ff;
  assign o_setup_to_default = set_def_ff;
  assign o_setup_to_fw      = set_fw_ff;

endmodule : ubr_boot_ctrl

// File: logic/ubr_i2c_master.sv
// ubr_i2c_master: byte-level i2c bus master (start, stop, write, read).
// assumes pull-ups on scl and sda; oe high pulls the line low.
`timescale 1ns/1ns

module ubr_i2c_master (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_tick,
  input  wire logic                  i_go,
  input  wire ubr_pkg::ubr_i2c_cmd_t i_cmd,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_nack,
  input  wire logic                  i_sda,
  output logic                       o_done,
  output logic [7:0]                 o_rdata,
  output logic                       o_ack,
  output logic                       o_scl_oe,
  output logic                       o_sda_oe
);

  typedef enum logic [4:0] {
    IS_IDLE  = 5'h01,
    IS_START = 5'h02,
    IS_BIT   = 5'h04,
    IS_STOP  = 5'h08,
    IS_DONE  = 5'h10
  } ubr_i2c_st_t;

  ubr_i2c_st_t st_ff, nxt_st;
  logic [1:0]  ph_ff, nxt_ph;
  logic [3:0]  bit_ff, nxt_bit;
  logic [8:0]  tx_ff, nxt_tx;
  logic [8:0]  rx_ff, nxt_rx;
  logic        scl_oe_ff, nxt_scl_oe;
  logic        sda_oe_ff, nxt_sda_oe;
  logic        done_ff, nxt_done;
  logic        sda_s1_ff;
  logic        sda_s2_ff;

  always_comb begin
    nxt_st     = st_ff;
    nxt_ph     = ph_ff;
    nxt_bit    = bit_ff;
    nxt_tx     = tx_ff;
    nxt_rx     = rx_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_done   = 1'b0;
    unique case (st_ff)
      IS_IDLE: begin
        nxt_ph  = 2'h0;
        nxt_bit = 4'h0;
        if (i_go) begin
          unique case (i_cmd)
            ubr_pkg::I2C_START: nxt_st = IS_START;
            ubr_pkg::I2C_STOP:  nxt_st = IS_STOP;
            ubr_pkg::I2C_WRITE: begin
              nxt_tx = {i_wdata, 1'b1};
              nxt_st = IS_BIT;
            end
            ubr_pkg::I2C_READ: begin
              nxt_tx = {8'hFF, i_nack};
              nxt_st = IS_BIT;
            end
          endcase
        end
      end
      IS_START: if (i_tick) begin
        nxt_ph = ph_ff + 2'h1;
        unique case (ph_ff)
          2'h0: nxt_sda_oe = 1'b0;
          2'h1: nxt_scl_oe = 1'b0;
          2'h2: nxt_sda_oe = 1'b1;
          2'h3: begin
            nxt_scl_oe = 1'b1;
            nxt_st     = IS_DONE;
          end
        endcase
      end
      IS_BIT: if (i_tick) begin
        nxt_ph = ph_ff + 2'h1;
        unique case (ph_ff)
          2'h0: nxt_sda_oe = ~tx_ff[8];
          2'h1: nxt_scl_oe = 1'b0;
          2'h2: nxt_rx = {rx_ff[7:0], sda_s2_ff};
          2'h3: begin
            nxt_scl_oe = 1'b1;
            nxt_tx     = {tx_ff[7:0], 1'b1};
            nxt_bit    = bit_ff + 4'h1;
            if (bit_ff == 4'h8) begin
              nxt_st = IS_DONE;
            end
          end
        endcase
      end
      IS_STOP: if (i_tick) begin
        nxt_ph = ph_ff + 2'h1;
        unique case (ph_ff)
          2'h0: nxt_sda_oe = 1'b1;
          2'h1: nxt_scl_oe = 1'b0;
          2'h2: nxt_sda_oe = 1'b0;
          2'h3: nxt_st     = IS_DONE;
        endcase
      end
      IS_DONE: begin
        nxt_done = 1'b1;
        nxt_st   = IS_IDLE;
      end
      default: nxt_st = IS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff     <= IS_IDLE;
      ph_ff     <= 2'h0;
      bit_ff    <= 4'h0;
      tx_ff     <= 9'h1FF;
      rx_ff     <= 9'h1FF;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      done_ff   <= 1'b0;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
    end else begin
      st_ff     <= nxt_st;
      ph_ff     <= nxt_ph;
      bit_ff    <= nxt_bit;
      tx_ff     <= nxt_tx;
      rx_ff     <= nxt_rx;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      done_ff   <= nxt_done;
      sda_s1_ff <= i_sda;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  assign o_done   = done_ff;
  assign o_rdata  = rx_ff[8:1];
  assign o_ack    = ~rx_ff[0];
  assign o_scl_oe = scl_oe_ff;
  assign o_sda_oe = sda_oe_ff;

endmodule : ubr_i2c_master

// File: logic/ubr_pkg.sv
// ubr_pkg: constants and types for the boot loader and re-enumeration control.
// assumes a single 100 MHz clock domain.

package ubr_pkg;

  // ----------------------------------------------------------------
  // clock and i2c timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned I2C_STD_HZ  = 100_000;
  localparam int unsigned I2C_FAST_HZ = 400_000;
  // quarter bit periods, rounded up so the bus never runs above its rate
  localparam int unsigned STD_QTR  = (CLK_HZ + 4 * I2C_STD_HZ - 1) / (4 * I2C_STD_HZ);
  localparam int unsigned FAST_QTR = (CLK_HZ + 4 * I2C_FAST_HZ - 1) / (4 * I2C_FAST_HZ);

  // ----------------------------------------------------------------
  // eeprom layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  CODE_ID      = 8'hC0;
  localparam logic [7:0]  CODE_LOAD    = 8'hC2;
  localparam logic [7:0]  EE_WR        = 8'hA0;
  localparam logic [7:0]  EE_RD        = 8'hA1;
  localparam logic [7:0]  EE_START_OFS = 8'h00;
  localparam logic [15:0] ID_BYTES     = 16'h0006;
  localparam logic [15:0] HDR_BYTES    = 16'h0004;

  // ----------------------------------------------------------------
  // built-in identity values (arbitrary, not a real maker or part)
  // ----------------------------------------------------------------
  localparam logic [15:0] DEF_VID = 16'h1234;
  localparam logic [15:0] DEF_PID = 16'h5678;
  localparam logic [15:0] DEF_DID = 16'h0001;

  localparam logic [1:0]  ENUM_MAX = 2'h2;

  typedef enum logic [1:0] {
    I2C_START = 2'h0,
    I2C_STOP  = 2'h1,
    I2C_WRITE = 2'h2,
    I2C_READ  = 2'h3
  } ubr_i2c_cmd_t;

  typedef enum logic [1:0] {
    BOOT_NONE = 2'h0,
    BOOT_ID   = 2'h1,
    BOOT_LOAD = 2'h2
  } ubr_boot_mode_t;

endpackage : ubr_pkg

// File: logic/ubr_tick.sv
// ubr_tick: quarter-bit enable pulse for the i2c master.
// assumes i_fast is steady from logic on the same clock.
`timescale 1ns/1ns

module ubr_tick #(
  parameter int unsigned STD_DIV  = ubr_pkg::STD_QTR,
  parameter int unsigned FAST_DIV = ubr_pkg::FAST_QTR,
  parameter int unsigned CW       = $clog2(STD_DIV + 1)
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_fast,
  output logic      o_tick
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [CW-1:0] lim;
  logic          tick_ff;
  logic          nxt_tick;

  always_comb begin
    lim      = i_fast ? CW'(FAST_DIV - 1) : CW'(STD_DIV - 1);
    nxt_tick = (cnt_ff >= lim);
    nxt_cnt  = nxt_tick ? '0 : cnt_ff + CW'(1);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

endmodule : ubr_tick

// File: sim/tb_top.sv
// tb_top: boot selection and re-enumeration scenarios for ubr_boot_ctrl.
// assumes pull-ups on scl and sda, modelled by resolving all enables.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
  logic        i_clk, i_rst, i_i2c_fast, i_soft_disconnect, i_request_handling_select;
  logic        i_setup_valid, scl_oe, sda_oe, ee_oe, ee_present, o_boot_done, o_cpu_hold;
  logic        o_builtin_desc, o_ram_we, o_dp_pullup, o_full_speed, o_setup_to_default;
  logic        o_setup_to_fw;
  logic [1:0]  o_boot_mode, o_enum_count;
  logic [15:0] o_vid, o_pid, o_did, o_ram_addr;
  logic [7:0]  o_ram_wdata;
  logic [15:0] wa [$];
  logic [7:0]  wd [$];
  int          mismatches, compares;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || ee_oe);

  ubr_boot_ctrl uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_i2c_fast(i_i2c_fast), .i_sda(sda), .o_scl_out(),
    .o_scl_oe(scl_oe), .o_sda_out(), .o_sda_oe(sda_oe), .i_soft_disconnect(i_soft_disconnect),
    .i_request_handling_select(i_request_handling_select), .i_setup_valid(i_setup_valid),
    .o_boot_done(o_boot_done), .o_cpu_hold(o_cpu_hold), .o_boot_mode(o_boot_mode),
    .o_vid(o_vid), .o_pid(o_pid), .o_did(o_did), .o_builtin_desc(o_builtin_desc),
    .o_ram_we(o_ram_we), .o_ram_addr(o_ram_addr), .o_ram_wdata(o_ram_wdata),
    .o_dp_pullup(o_dp_pullup), .o_full_speed(o_full_speed), .o_enum_count(o_enum_count),
    .o_setup_to_default(o_setup_to_default), .o_setup_to_fw(o_setup_to_fw)
  );
  ubr_ee_model ee (.i_scl(scl), .i_sda(sda), .i_present(ee_present), .o_sda_oe(ee_oe));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = !i_clk;
  end

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic fill(input logic [55:0] v);
    for (int i = 0; i < 7; i++) ee.mem[i] = v[55 - 8 * i -: 8];
  endtask : fill

  task automatic boot(input logic pres, input logic fast);
    int n;
    ee_present = pres;
    wa.delete();
    wd.delete();
    @(posedge i_clk);
    i_rst <= 1'b1;
    i_i2c_fast <= fast;
    i_soft_disconnect <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      if (o_ram_we === 1'b1) begin
        wa.push_back(o_ram_addr);
        wd.push_back(o_ram_wdata);
      end
      n++;
    end while (o_boot_done !== 1'b1 && n < 60000);
    if (n >= 60000) begin
      mismatches++;
      stop_test();
    end
    repeat (2) @(posedge i_clk);
    #1;
  endtask : boot

  task automatic chk_boot(input logic [1:0] md, input logic [15:0] v, p, d);
    `CHK("mode", md, o_boot_mode)
    `CHK("builtin", md != 2'h2, o_builtin_desc)
    `CHK("hold", 1'b0, o_cpu_hold)
    `CHK("vid", v, o_vid)
    `CHK("pid", p, o_pid)
    `CHK("did", d, o_did)
  endtask : chk_boot

  task automatic attach(input logic sel, input logic disc, input logic [1:0] cnt);
    @(posedge i_clk);
    i_request_handling_select <= sel;
    @(posedge i_clk);
    i_soft_disconnect <= disc;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("pullup", !disc, o_dp_pullup)
    `CHK("enum", cnt, o_enum_count)
  endtask : attach

  task automatic setup(input logic to_def, input logic to_fw);
    @(posedge i_clk);
    i_setup_valid <= 1'b1;
    @(posedge i_clk);
    i_setup_valid <= 1'b0;
    #1;
    `CHK("to_default", to_def, o_setup_to_default)
    `CHK("to_fw", to_fw, o_setup_to_fw)
  endtask : setup

  task automatic t_none;
    boot(1'b0, 1'b0);
    chk_boot(2'h0, ubr_pkg::DEF_VID, ubr_pkg::DEF_PID, ubr_pkg::DEF_DID);
    `CHK("full_speed", 1'b1, o_full_speed)
    `CHK("lines_low", 2'h0, {uut.o_scl_out, uut.o_sda_out})
  endtask : t_none

  task automatic t_odd;
    fill(56'h55_C0_C2_00_00_00_00);
    boot(1'b1, 1'b1);
    chk_boot(2'h0, ubr_pkg::DEF_VID, ubr_pkg::DEF_PID, ubr_pkg::DEF_DID);
  endtask : t_odd

  task automatic t_ids;
    fill(56'hC0_EF_BE_21_43_07_0A);
    boot(1'b1, 1'b1);
    chk_boot(2'h1, 16'hBEEF, 16'h4321, 16'h0A07);
  endtask : t_ids

  task automatic t_load;
    fill(56'hC2_00_02_01_00_AB_CD);
    boot(1'b1, 1'b1);
    `CHK("mode", 2'h2, o_boot_mode)
    `CHK("writes", 2, wa.size())
    for (int i = 0; i < 2 && i < wa.size(); i++) begin
      `CHK("ram_addr", 16'h0100 + 16'(i), wa[i])
      `CHK("ram_data", (i == 0) ? 8'hAB : 8'hCD, wd[i])
    end
  endtask : t_load

  task automatic t_request_handling_select;
    attach(1'b0, 1'b0, 2'h1);
    setup(1'b1, 1'b0);
    attach(1'b0, 1'b1, 2'h1);
    setup(1'b0, 1'b0);
    attach(1'b1, 1'b0, 2'h2);
    setup(1'b0, 1'b1);
    attach(1'b1, 1'b1, 2'h2);
    attach(1'b1, 1'b0, 2'h2);
  endtask : t_request_handling_select

  initial begin
    mismatches = 0;
    compares = 0;
    ee_present = 1'b0;
    i_rst = 1'b1;
    i_i2c_fast = 1'b0;
    i_soft_disconnect = 1'b1;
    i_request_handling_select = 1'b0;
    i_setup_valid = 1'b0;
    t_none();
    t_odd();
    t_load();
    t_ids();
    t_request_handling_select();
    stop_test();
  end
endmodule : tb_top

// File: sim/ubr_boot_ctrl_props.sv
// ubr_boot_ctrl_props: concurrent checks on the boot and re-enumeration ports.
// assumes the default identity parameters and one clock domain.
`timescale 1ns/1ns

module ubr_boot_ctrl_props (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_soft_disconnect,
  input  wire logic        i_request_handling_select,
  input  wire logic        i_setup_valid,
  input  wire logic        o_boot_done,
  input  wire logic        o_cpu_hold,
  input  wire logic [1:0]  o_boot_mode,
  input  wire logic [15:0] o_vid,
  input  wire logic [15:0] o_pid,
  input  wire logic        o_builtin_desc,
  input  wire logic        o_dp_pullup,
  input  wire logic        o_full_speed,
  input  wire logic [1:0]  o_enum_count,
  input  wire logic        o_setup_to_default,
  input  wire logic        o_setup_to_fw
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_attach_pullup: assert property (o_boot_done && !i_soft_disconnect |=> o_dp_pullup)
    else $error("pull-up not enabled after reconnect");
  a_detach_pullup: assert property (i_soft_disconnect || !o_boot_done |=> !o_dp_pullup)
    else $error("pull-up enabled while disconnected");
  a_setup_default: assert property (i_setup_valid && o_dp_pullup && !i_request_handling_select
    |=> o_setup_to_default && !o_setup_to_fw)
    else $error("setup not routed to default logic");
  a_setup_fw: assert property (i_setup_valid && o_dp_pullup && i_request_handling_select
    |=> o_setup_to_fw && !o_setup_to_default)
    else $error("setup not routed to firmware");
  a_setup_drop: assert property (!(i_setup_valid && o_dp_pullup)
    |=> !o_setup_to_fw && !o_setup_to_default)
    else $error("setup routed while detached");
  a_enum_step: assert property ($rose(o_dp_pullup) && $past(o_enum_count) != 2'h2
    |-> o_enum_count == $past(o_enum_count) + 2'h1)
    else $error("attach count did not step");
  a_boot_stable: assert property (o_boot_done |=> o_boot_done && $stable(o_boot_mode)
    && $stable(o_vid))
    else $error("boot result changed after boot");
  a_ids_default: assert property (!o_boot_done
    |-> o_vid == ubr_pkg::DEF_VID && o_pid == ubr_pkg::DEF_PID)
    else $error("identity not default during boot");
  a_hold_cpu: assert property (o_cpu_hold != o_boot_done)
    else $error("cpu hold not inverse of boot done");
  a_desc_mode: assert property (o_boot_done && $past(o_boot_done)
    |-> o_builtin_desc == (o_boot_mode != 2'h2))
    else $error("descriptor source wrong for boot mode");
  a_speed_full: assert property (o_full_speed)
    else $error("full speed not signalled");
endmodule : ubr_boot_ctrl_props

bind ubr_boot_ctrl ubr_boot_ctrl_props u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_soft_disconnect(i_soft_disconnect),
  .i_request_handling_select(i_request_handling_select), .i_setup_valid(i_setup_valid),
  .o_boot_done(o_boot_done), .o_cpu_hold(o_cpu_hold), .o_boot_mode(o_boot_mode),
  .o_vid(o_vid), .o_pid(o_pid), .o_builtin_desc(o_builtin_desc), .o_dp_pullup(o_dp_pullup),
  .o_full_speed(o_full_speed), .o_enum_count(o_enum_count),
  .o_setup_to_default(o_setup_to_default), .o_setup_to_fw(o_setup_to_fw)
);

// File: sim/ubr_ee_model.sv
// ubr_ee_model: behavioural i2c serial eeprom at 7-bit address 0x50.
// assumes the bench resolves the open-drain lines; oe high pulls sda low.
`timescale 1ns/1ns

module ubr_ee_model (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_present,
  output logic      o_sda_oe
);
  logic [7:0] mem [0:15];
  logic [7:0] sh;
  logic [3:0] ptr;
  int         cnt;
  logic       act, first, rd;

  initial begin
    o_sda_oe = 1'b0;
    act = 1'b0;
  end
  // start condition
  always @(negedge i_sda) if (i_scl) begin
    cnt = 0;
    act = i_present;
    first = 1'b1;
    rd = 1'b0;
  end
  // stop condition
  always @(posedge i_sda) if (i_scl) act = 1'b0;
  // bits sampled on master clock; master nack ends read
  always @(posedge i_scl) if (act) begin
    if (cnt < 8) sh = {sh[6:0], i_sda};
    else if (rd && i_sda) act = 1'b0;
    cnt = cnt + 1;
  end
  always @(negedge i_scl) begin
    if (!act) o_sda_oe = 1'b0;
    else if (cnt == 8 && !rd) begin
      act = !first || sh[7:1] == 7'h50;
      o_sda_oe = act;
      if (first) rd = sh[0];
      else ptr = sh[3:0];
      first = 1'b0;
    end else if (cnt == 8) begin
      o_sda_oe = 1'b0;
      ptr = ptr + 4'h1;
    end else begin
      if (cnt == 9) cnt = 0;
      o_sda_oe = rd && !mem[ptr][7 - cnt];
    end
  end
endmodule : ubr_ee_model
